// ---- rtl/ubk_break_unit.sv ----
// Top of the user break unit: register slave, match pipeline, request.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Any of requester, kind or direction pair at 00 blocks all new matches.
// - A cycle meeting every programmed condition raises the break request.
// - A paired on-chip fetch matches on either instruction's own address.
// - A hit on the second pair instruction waits until the first executed.
// - Fetch break requests before execution; saved address is break address.
// - Delay-slot or masked-follower fetch runs first; core picks next PC.
// - Data breaks are imprecise; core saves address after last executed.
// - Fetch combined with write direction never matches.
// - Odd fetch addresses never match, except first fetch after a branch.
// - DMA requester combined with instruction fetch never matches.
// - Word data break at an odd address never matches.
// - A captured second-instruction hit survives later register changes.
// - Taken branches and traps make two overrun fetches before the target.
// - Hits on overrun fetches still raise the break request.
// - At least two cycles pass from matching fetch to the request.
// - Selects 54h, 6Ah and A7h give the documented cycle classes.
// - Requester pair: 00 none, 01 core, 10 DMA, 11 both.
// - Kind pair: 00 none, 01 fetch, 10 data, 11 both.
// - Size pair: 00 ignored, 01 byte, 10 word, 11 long; fetch is word.
// - A set mask bit drops that address bit from the comparison.
module ubk_break_unit #(
  parameter int AXI_ADDR_W = 32
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  cyc_valid,
  input  wire logic [31:0]           cyc_addr,
  input  wire logic                  cyc_dma,
  input  wire logic                  cyc_fetch,
  input  wire logic                  cyc_write,
  input  wire logic [1:0]            cyc_size,
  input  wire logic                  cyc_pair,
  input  wire logic                  cyc_branch_first,
  input  wire logic                  first_executed,
  input  wire logic                  brk_ack,
  output logic                       brk_req,
  output logic [31:0]                brk_pc,
  output logic                       brk_on_fetch,
  output logic                       brk_on_second
);

  // Register port decoding needs at least the four word offsets.
  if (AXI_ADDR_W < 4) begin : g_bad_width
    $error("AXI_ADDR_W must be at least 4");
  end

  // Whole state of the block in one record.
  typedef struct packed {
    logic        aw_have;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] brk_addr;
    logic [31:0] brk_mask;
    logic [7:0]  cyc_sel;
    logic        hit;
    logic [31:0] hit_pc;
    logic        hit_fetch;
    logic        hit_second;
    logic        sec_pend;
    logic [31:0] sec_pc;
    logic        req;
    logic [31:0] pc;
    logic        on_fetch;
    logic        on_second;
  } ubk_state_s;

  ubk_state_s s_q;
  ubk_state_s s_d;

  logic        hit_first;
  logic        hit_pair;
  logic [31:0] pair_addr;

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // True when the address falls in the 16-byte block that holds the four registers.
  function automatic logic addr_mapped(input logic [AXI_ADDR_W-1:0] a);
    return (a >> 4) == '0;
  endfunction : addr_mapped

  // The second instruction of a pair sits one halfword above the first.
  assign pair_addr = cyc_addr + ubk_pkg::PAIR_STEP;

  // Overrun fetches are ordinary fetch cycles here; nothing filters them.
  ubk_match u_first (
    .brk_addr     (s_q.brk_addr),
    .brk_mask     (s_q.brk_mask),
    .sel          (s_q.cyc_sel),
    .addr         (cyc_addr),
    .is_dma       (cyc_dma),
    .is_fetch     (cyc_fetch),
    .is_write     (cyc_write),
    .size         (cyc_size),
    .branch_first (cyc_branch_first),
    .hit          (hit_first)
  );

  // Second comparator serves the upper instruction of an on-chip pair.
  ubk_match u_second (
    .brk_addr     (s_q.brk_addr),
    .brk_mask     (s_q.brk_mask),
    .sel          (s_q.cyc_sel),
    .addr         (pair_addr),
    .is_dma       (cyc_dma),
    .is_fetch     (cyc_fetch),
    .is_write     (cyc_write),
    .size         (cyc_size),
    .branch_first (1'b0),
    .hit          (hit_pair)
  );

  // Next-state logic for the slave and the break pipeline.
  always_comb begin
    logic do_write;
    logic rd_mapped;
    logic [3:0] rd_off;
    logic [3:0] wr_off;
    logic cyc_hit1;
    logic cyc_hit2;
    do_write  = 1'b0;
    rd_mapped = 1'b0;
    rd_off    = 4'h0;
    wr_off    = 4'h0;
    cyc_hit1  = 1'b0;
    cyc_hit2  = 1'b0;
    s_d = s_q;

    // Address and data are taken independently, in either order.
    if (s_axi_awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // The write lands once both halves are held and no response waits.
    do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    if (do_write) begin
      wr_off = s_q.aw_addr[3:0];
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = ubk_pkg::RESP_OKAY;
      if (!addr_mapped(s_q.aw_addr)) begin
        s_d.bresp = ubk_pkg::RESP_SLVERR;
      end else if (wr_off == ubk_pkg::OFF_BRK_ADDR) begin
        s_d.brk_addr = lane_merge(s_q.brk_addr, s_q.w_data, s_q.w_strb);
      end else if (wr_off == ubk_pkg::OFF_BRK_MASK) begin
        s_d.brk_mask = lane_merge(s_q.brk_mask, s_q.w_data, s_q.w_strb);
      end else if (wr_off == ubk_pkg::OFF_CYCLE_SEL) begin
        if (s_q.w_strb[0]) begin
          s_d.cyc_sel = s_q.w_data[7:0];
        end
      end else if (wr_off != ubk_pkg::OFF_STATUS) begin
        s_d.bresp = ubk_pkg::RESP_SLVERR;
      end
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      rd_off    = s_axi_araddr[3:0];
      rd_mapped = addr_mapped(s_axi_araddr);
      s_d.rvalid = 1'b1;
      s_d.rresp  = ubk_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (!rd_mapped) begin
        s_d.rresp = ubk_pkg::RESP_SLVERR;
      end else if (rd_off == ubk_pkg::OFF_BRK_ADDR) begin
        s_d.rdata = s_q.brk_addr;
      end else if (rd_off == ubk_pkg::OFF_BRK_MASK) begin
        s_d.rdata = s_q.brk_mask;
      end else if (rd_off == ubk_pkg::OFF_CYCLE_SEL) begin
        s_d.rdata[7:0] = s_q.cyc_sel;
      end else if (rd_off == ubk_pkg::OFF_STATUS) begin
        s_d.rdata[ubk_pkg::ST_REQ]    = s_q.req;
        s_d.rdata[ubk_pkg::ST_SECOND] = s_q.on_second;
        s_d.rdata[ubk_pkg::ST_FETCH]  = s_q.on_fetch;
        s_d.rdata[ubk_pkg::ST_HELD]   = s_q.sec_pend;
      end else begin
        s_d.rresp = ubk_pkg::RESP_SLVERR;
      end
    end

    // Stage one: capture a match of this bus cycle.
    cyc_hit1 = cyc_valid && hit_first;
    cyc_hit2 = cyc_valid && cyc_pair && cyc_fetch && hit_pair;
    s_d.hit = 1'b0;
    if (cyc_hit1) begin
      // The first instruction wins; it must break before it runs.
      s_d.hit        = 1'b1;
      s_d.hit_pc     = cyc_addr;
      s_d.hit_fetch  = cyc_fetch;
      s_d.hit_second = 1'b0;
    end else if (cyc_hit2) begin
      // Latched now, so later register writes cannot cancel it.
      s_d.sec_pend = 1'b1;
      s_d.sec_pc   = pair_addr;
    end else if (s_q.sec_pend && first_executed) begin
      s_d.sec_pend   = 1'b0;
      s_d.hit        = 1'b1;
      s_d.hit_pc     = s_q.sec_pc;
      s_d.hit_fetch  = 1'b1;
      s_d.hit_second = 1'b1;
    end

    // Stage two: a held request; a new hit beats an acknowledge.
    if (brk_ack) begin
      s_d.req = 1'b0;
    end
    if (s_q.hit) begin
      s_d.req       = 1'b1;
      s_d.pc        = s_q.hit_pc;
      s_d.on_fetch  = s_q.hit_fetch;
      s_d.on_second = s_q.hit_second;
    end
  end

  // State register with synchronous reset to constants.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q          <= '0;
      s_q.brk_addr <= ubk_pkg::RST_BRK_ADDR;
      s_q.brk_mask <= ubk_pkg::RST_BRK_MASK;
      s_q.cyc_sel  <= ubk_pkg::RST_CYCLE_SEL;
    end else begin
      s_q <= s_d;
    end
  end

  // Handshake outputs follow the holding flags; data comes from flops.
  assign s_axi_awready = !s_q.aw_have;
  assign s_axi_wready  = !s_q.w_have;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  // Level request stays up until acknowledged, however long that takes.
  assign brk_req       = s_q.req;
  assign brk_pc        = s_q.pc;
  assign brk_on_fetch  = s_q.on_fetch;
  assign brk_on_second = s_q.on_second;

endmodule : ubk_break_unit

`default_nettype wire

// ---- rtl/ubk_match.sv ----
// Combinational comparison of one bus address and its attributes.
`timescale 1ns/1ps
`default_nettype none

module ubk_match (
  input  wire logic [31:0] brk_addr,
  input  wire logic [31:0] brk_mask,
  input  wire logic [7:0]  sel,
  input  wire logic [31:0] addr,
  input  wire logic        is_dma,
  input  wire logic        is_fetch,
  input  wire logic        is_write,
  input  wire logic [1:0]  size,
  input  wire logic        branch_first,
  output logic             hit
);

  logic       req_ok;
  logic       kind_ok;
  logic       dir_ok;
  logic       size_ok;
  logic       addr_ok;
  logic       pairs_set;
  logic       odd_fetch;
  logic       odd_word;
  logic       never_hit;
  logic [1:0] eff_size;

  // Attribute agreement; a requester, kind or direction pair at zero selects nothing at all.
  always_comb begin
    pairs_set = (sel[7:6] != 2'b00) && (sel[5:4] != 2'b00)
             && (sel[3:2] != 2'b00);
    req_ok  = is_dma ? sel[ubk_pkg::SEL_REQ_DMA]
                     : sel[ubk_pkg::SEL_REQ_CORE];
    kind_ok = is_fetch ? sel[ubk_pkg::SEL_KIND_FET]
                       : sel[ubk_pkg::SEL_KIND_DAT];
    // Fetches are always reads, so a fetch-with-write select never hits.
    dir_ok  = is_write ? sel[ubk_pkg::SEL_DIR_WR]
                       : sel[ubk_pkg::SEL_DIR_RD];
    // Fetches count as word accesses whatever the port width is.
    eff_size = is_fetch ? ubk_pkg::SIZE_WORD : size;
    size_ok = (sel[1:0] == ubk_pkg::SIZE_ANY)
           || (sel[1:0] == eff_size);
    addr_ok = (((addr ^ brk_addr) & ~brk_mask) == 32'h0000_0000);
    // Odd fetch only exists as the first fetch after a branch.
    odd_fetch = is_fetch && addr[0] && !branch_first;
    odd_word  = !is_fetch && (size == ubk_pkg::SIZE_WORD)
             && (addr[0] || (brk_addr[0] && !brk_mask[0]));
    // The transfer unit never fetches and fetches never write, so a select
    // that asks for either would otherwise fire on a cycle that cannot be.
    never_hit = (is_dma && is_fetch) || (is_fetch && is_write);
    hit = pairs_set && req_ok && kind_ok && dir_ok && size_ok
       && addr_ok && !odd_fetch && !odd_word && !never_hit;
  end

endmodule : ubk_match

`default_nettype wire

// ---- rtl/ubk_pkg.sv ----
// Package of register offsets, field layouts and encodings of the break unit.
package ubk_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [3:0] OFF_BRK_ADDR   = 4'h0;
  localparam logic [3:0] OFF_BRK_MASK   = 4'h4;
  localparam logic [3:0] OFF_CYCLE_SEL  = 4'h8;
  localparam logic [3:0] OFF_STATUS     = 4'hc;

  // Reset values of the writable registers.
  localparam logic [31:0] RST_BRK_ADDR  = 32'h0000_0000;
  localparam logic [31:0] RST_BRK_MASK  = 32'h0000_0000;
  localparam logic [7:0]  RST_CYCLE_SEL = 8'h00;

  // Field positions inside the cycle-select register.
  localparam int SEL_REQ_DMA  = 7;
  localparam int SEL_REQ_CORE = 6;
  localparam int SEL_KIND_DAT = 5;
  localparam int SEL_KIND_FET = 4;
  localparam int SEL_DIR_WR   = 3;
  localparam int SEL_DIR_RD   = 2;
  localparam int SEL_SIZE_HI  = 1;
  localparam int SEL_SIZE_LO  = 0;

  // Field positions inside the status register.
  localparam int ST_REQ    = 0;
  localparam int ST_SECOND = 1;
  localparam int ST_FETCH  = 2;
  localparam int ST_HELD   = 3;

  // Offset of the second instruction of an on-chip fetched pair.
  localparam logic [31:0] PAIR_STEP = 32'h0000_0002;

  // Operand size encodings, shared by the bus cycle and the select field.
  typedef enum logic [1:0] {
    SIZE_ANY  = 2'b00,
    SIZE_BYTE = 2'b01,
    SIZE_WORD = 2'b10,
    SIZE_LONG = 2'b11
  } ubk_size_e;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ubk_pkg

// ---- testbench/ubk_break_unit_chk.sv ----
// Checker of break request timing and bus answers of the break unit.
`timescale 1ns/1ps
`default_nettype none

module ubk_break_unit_chk (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic        cyc_fetch,
  input wire logic [1:0]  cyc_size,
  input wire logic        cyc_branch_first,
  input wire logic        first_executed,
  input wire logic        brk_ack,
  input wire logic        brk_req,
  input wire logic [31:0] brk_pc,
  input wire logic        brk_on_fetch,
  input wire logic        brk_on_second
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Cycles that may never start a request, as seen two edges later.
  wire logic odd_fet = cyc_valid & cyc_fetch & cyc_addr[0] & ~cyc_branch_first;
  wire logic odd_wrd = cyc_valid & ~cyc_fetch & cyc_addr[0] &
                       (cyc_size == 2'b10);

  req_cause_a: assert property ($rose(brk_req) |->
    $past(cyc_valid, 2) || $past(first_executed, 2))
    else $error("request without a cycle two edges back");
  odd_fetch_a: assert property ($rose(brk_req) &&
    !$past(first_executed, 2) |-> !$past(odd_fet, 2))
    else $error("odd fetch raised a request");
  odd_word_a: assert property ($rose(brk_req) &&
    !$past(first_executed, 2) |-> !$past(odd_wrd, 2))
    else $error("odd word data raised a request");
  pc_first_a: assert property ($rose(brk_req) && !brk_on_second |->
    brk_pc == $past(cyc_addr, 2))
    else $error("saved address differs from cycle address");
  second_kind_a: assert property (brk_req && brk_on_second |->
    brk_on_fetch)
    else $error("second instruction hit not marked as fetch");
  second_wait_a: assert property ($rose(brk_req) && brk_on_second |->
    $past(first_executed, 2))
    else $error("second hit raised before first executed");
  req_hold_a: assert property (brk_req && !brk_ack |=> brk_req)
    else $error("request dropped without acceptance");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
endmodule : ubk_break_unit_chk

bind ubk_break_unit ubk_break_unit_chk u_chk (.clk_sys, .srst,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .cyc_valid, .cyc_addr, .cyc_fetch,
  .cyc_size, .cyc_branch_first, .first_executed, .brk_ack, .brk_req,
  .brk_pc, .brk_on_fetch, .brk_on_second);

`default_nettype wire

// ---- testbench/ubk_break_unit_test.sv ----
// Bench driving register writes and bus cycles into the break unit.
`timescale 1ns/1ps
`default_nettype none

module ubk_break_unit_test;
  logic        clk_sys, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, cyc_valid;
  logic        cyc_dma, cyc_fetch, cyc_write, cyc_pair, cyc_branch_first;
  logic        first_executed, brk_ack, brk_req, brk_on_fetch;
  logic        brk_on_second, other_pend;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cyc_size;
  logic [3:0]  s_axi_wstrb, mask_lvl;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] cyc_addr, brk_pc;
  int          n_fail, checks;

  ubk_break_unit #(.AXI_ADDR_W(32)) uut (.clk_sys, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cyc_valid,
    .cyc_addr, .cyc_dma, .cyc_fetch, .cyc_write, .cyc_size, .cyc_pair,
    .cyc_branch_first, .first_executed, .brk_ack, .brk_req, .brk_pc,
    .brk_on_fetch, .brk_on_second);
  ubk_interrupt_controller_unit_model u_interrupt_controller_unit (.clk_sys, .srst, .brk_req, .mask_lvl,
    .other_pend, .brk_ack);

  // Free running 25 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // A wait that runs out counts as a mismatch and ends the run.
  task guard(input int n);
    if (n > 60) begin
      n_fail++;
      conclude;
    end
  endtask : guard

  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rs);
    logic ta, tw, tb;
    int   n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    n = 0;
    while (!tb) begin
      #1;
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      tb = s_axi_bvalid;
      if (tb) chk(32'(s_axi_bresp), 32'(rs));
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      n++;
      guard(n);
    end
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rs);
    logic ta, tb;
    int   n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tb = 1'b0;
    n = 0;
    while (!tb) begin
      #1;
      ta = s_axi_arready & s_axi_arvalid;
      tb = s_axi_rvalid;
      if (tb) chk(32'(s_axi_rresp), 32'(rs));
      if (tb && rs == 2'b00) chk(s_axi_rdata, d);
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) s_axi_rready <= 1'b0;
      n++;
      guard(n);
    end
  endtask : rd

  // One bus cycle; attr packs requester, fetch, write and branch-first.
  task cyc(input logic [31:0] a, input logic [3:0] attr, input logic [1:0] sz,
           input logic pr);
    @(posedge clk_sys);
    cyc_valid <= 1'b1;
    cyc_addr <= a;
    {cyc_dma, cyc_fetch, cyc_write, cyc_branch_first} <= attr;
    cyc_size <= sz;
    cyc_pair <= pr;
  endtask : cyc

  task idle;
    @(posedge clk_sys);
    cyc_valid <= 1'b0;
    cyc_pair <= 1'b0;
  endtask : idle

  task settle;
    int n;
    n = 0;
    while (brk_req !== 1'b0) begin
      @(posedge clk_sys);
      #1;
      n++;
      guard(n);
    end
  endtask : settle

  task setup(input logic [31:0] bar, input logic [31:0] msk,
             input logic [7:0] sel);
    settle;
    wr(32'h0, bar, 2'b00);
    wr(32'h4, msk, 2'b00);
    wr(32'h8, {24'h0, sel}, 2'b00);
  endtask : setup

  // Program, send one cycle, expect the request exactly two edges later.
  task run(input logic [31:0] bar, input logic [31:0] msk,
           input logic [7:0] sel, input logic [31:0] a,
           input logic [3:0] attr, input logic [1:0] sz, input logic hit);
    setup(bar, msk, sel);
    cyc(a, attr, sz, 1'b0);
    idle;
    #1;
    chk(32'(brk_req), 32'h0);
    @(posedge clk_sys);
    #1;
    chk(32'(brk_req), 32'(hit));
    if (hit) chk(brk_pc, a);
    if (hit) chk(32'(brk_on_fetch), 32'(attr[2]));
  endtask : run

  // Main sequence: reset, map, cycle classes, pairs, overrun, deferral.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     cyc_valid, cyc_dma, cyc_fetch, cyc_write, cyc_pair, cyc_branch_first,
     first_executed, other_pend} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, cyc_addr} = '0;
    cyc_size = 2'b00;
    s_axi_wstrb = 4'hf;
    mask_lvl = 4'he;
    n_fail = 0;
    checks = 0;
    srst = 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rd(32'h0, 32'h0, 2'b00);
    rd(32'h4, 32'h0, 2'b00);
    rd(32'h8, 32'h0, 2'b00);
    wr(32'hc, 32'hf, 2'b00);
    rd(32'hc, 32'h0, 2'b00);
    wr(32'h10, 32'h1, 2'b10);
    rd(32'h10, 32'h0, 2'b10);
    wr(32'h8, 32'hffff, 2'b00);
    rd(32'h8, 32'hff, 2'b00);
    run(32'h404, 0, 8'h54, 32'h404, 4'b0100, 2'b10, 1);
    run(32'h15389c, 0, 8'h58, 32'h15389c, 4'b0100, 2'b10, 0);
    run(32'h30147, 0, 8'h54, 32'h30147, 4'b0100, 2'b10, 0);
    run(32'h30147, 0, 8'h54, 32'h30147, 4'b0101, 2'b10, 1);
    run(32'h123456, 0, 8'h6a, 32'h123456, 4'b0010, 2'b10, 1);
    run(32'ha80391, 0, 8'h66, 32'ha80391, 4'b0000, 2'b10, 0);
    run(32'h76bcdc, 0, 8'ha7, 32'h76bcdc, 4'b1000, 2'b11, 1);
    run(32'h2345c8, 0, 8'h94, 32'h2345c8, 4'b1100, 2'b10, 0);
    run(32'h404, 0, 8'h14, 32'h404, 4'b0100, 2'b10, 0);
    run(32'h404, 0, 8'h44, 32'h404, 4'b0100, 2'b10, 0);
    run(32'h404, 0, 8'h50, 32'h404, 4'b0100, 2'b10, 0);
    run(32'h404, 32'hff, 8'h54, 32'h4f0, 4'b0100, 2'b10, 1);
    run(32'h404, 32'hff, 8'h54, 32'h5f0, 4'b0100, 2'b10, 0);
    run(32'h100, 0, 8'he5, 32'h100, 4'b1000, 2'b01, 1);
    run(32'h100, 0, 8'he5, 32'h100, 4'b0000, 2'b10, 0);
    run(32'h100, 0, 8'hbe, 32'h100, 4'b1010, 2'b10, 1);
    run(32'h100, 0, 8'h6b, 32'h100, 4'b0010, 2'b10, 0);
    // Second instruction of a pair, then the select is cleared at once.
    setup(32'h102, 32'h0, 8'h54);
    cyc(32'h100, 4'b0100, 2'b10, 1'b1);
    idle;
    wr(32'h8, 32'h0, 2'b00);
    rd(32'hc, 32'h8, 2'b00);
    #1;
    chk(32'(brk_req), 32'h0);
    @(posedge clk_sys);
    first_executed <= 1'b1;
    @(posedge clk_sys);
    first_executed <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(32'(brk_req), 32'h1);
    chk(32'(brk_on_second), 32'h1);
    chk(brk_pc, 32'h102);
    // Back-to-back overrun fetches, the last one matching.
    setup(32'h204, 32'h0, 8'h54);
    cyc(32'h200, 4'b0100, 2'b10, 1'b0);
    cyc(32'h202, 4'b0100, 2'b10, 1'b0);
    cyc(32'h204, 4'b0100, 2'b10, 1'b0);
    idle;
    @(posedge clk_sys);
    #1;
    chk(brk_pc, 32'h204);
    // A mask level of 15 and an earlier interrupt both defer acceptance.
    settle;
    mask_lvl <= 4'hf;
    run(32'h404, 0, 8'h54, 32'h404, 4'b0100, 2'b10, 1);
    rd(32'hc, 32'h5, 2'b00);
    repeat (20) @(posedge clk_sys);
    mask_lvl <= 4'he;
    other_pend <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    chk(32'(brk_req), 32'h1);
    other_pend <= 1'b0;
    settle;
    chk(32'(brk_req), 32'h0);
    conclude;
  end
endmodule : ubk_break_unit_test

`default_nettype wire

// ---- testbench/ubk_interrupt_controller_unit_model.sv ----
// Interrupt controller stand-in that accepts or defers the break request.
`timescale 1ns/1ps
`default_nettype none

module ubk_interrupt_controller_unit_model (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       brk_req,
  input  wire logic [3:0] mask_lvl,
  input  wire logic       other_pend,
  output logic            brk_ack
);
  // One accept pulse per request; an earlier interrupt or a mask level
  // of 15 defers it, so the request must wait without being lost.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      brk_ack <= 1'b0;
    end else begin
      brk_ack <= brk_req & ~brk_ack & (mask_lvl <= 4'he)
                 & ~other_pend;
    end
  end
endmodule : ubk_interrupt_controller_unit_model

`default_nettype wire
